// ==== src/fmrc_pkg.sv ====
// Purpose: shared constants and types for the flash mode/reset control
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes:   command codes and block count are plain defaults
package fmrc_pkg;
    localparam int          BLOCK_COUNT     = 16;
    localparam int          BLOCK_IDX_W     = 4;
    localparam int          ADDR_W          = 20;
    localparam int          BLOCK_SHIFT     = 16;
    localparam int          BUSY_CYCLES_W   = 16;
    localparam logic [15:0] OP_CYCLES       = 16'h0040;
    localparam logic [15:0] RESET_LAT_CYCLES = 16'h0008;
    localparam int          READY_BIT       = 7;
    localparam logic [7:0]  CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0]  CMD_READ_ID     = 8'h90;
    localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
    localparam logic [7:0]  CMD_CLR_STATUS  = 8'h50;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0]  CMD_ERASE_GO    = 8'hd0;
    localparam logic [7:0]  CMD_PROG_SETUP  = 8'h40;
    localparam logic [7:0]  CMD_PROG_SETUP2 = 8'h10;
    localparam logic [BLOCK_COUNT-1:0] LOCK_RESET = {BLOCK_COUNT{1'b1}};
    localparam logic [7:0]  STATUS_RESET    = 8'h80;

    typedef enum logic [2:0] {
        FMRC_RD_ARRAY  = 3'b000,
        FMRC_RD_ID     = 3'b001,
        FMRC_RD_STATUS = 3'b010,
        FMRC_RD_LOCK   = 3'b011,
        FMRC_RD_RANDOM = 3'b100,
        FMRC_RD_RSTAT  = 3'b101,
        FMRC_RD_GPI    = 3'b110
    } fmrc_read_mode_t;

    typedef enum logic [1:0] {
        FMRC_IDLE     = 2'b00,
        FMRC_SETUP_ER = 2'b01,
        FMRC_SETUP_PR = 2'b10,
        FMRC_BUSY     = 2'b11
    } fmrc_wsm_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } fmrc_cmd_t;

    typedef struct packed {
        logic                   valid;
        logic [BLOCK_IDX_W-1:0] block;
    } fmrc_unlock_t;
endpackage

// ==== src/fmrc_pin_sync.sv ====
// Purpose: three-stage synchroniser for asynchronous pins
// Assumes: pins change slowly against core_clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
module fmrc_pin_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] st1_ff;
    logic [WIDTH-1:0] st2_ff;
    logic [WIDTH-1:0] st3_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st1_ff <= INIT;
            st2_ff <= INIT;
            st3_ff <= INIT;
        end else begin
            st1_ff <= pinIn;
            st2_ff <= st1_ff;
            st3_ff <= st2_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    pinOut[i] <= INIT[i];
                end else if (st2_ff[i] == st3_ff[i]) begin
                    pinOut[i] <= st3_ff[i];
                end
            end
        end
    endgenerate
endmodule // fmrc_pin_sync

// ==== src/fmrc_mode_reset_ctrl.sv ====
// What this block does
// - mux mode ready_busy_out copies status bit 7
// - bit 7 one ready, zero busy
// - power-up and reset exit enter read-array
// - array, id, inputs, status readable regardless supply
// - lock, random and random-status reads supported
// - host writes start commands through command intake
// - command write accepted at any valid address
// - hub_bus_lines float when not selected
// - reset or init low deselects, floats, idles
// - reset return locks every block
// - reset aborts operation, adds latency, data invalid
// - program supply lockout refuses program and erase
// - core supply lockout blocks every write
// Purpose: mode, output enable and reset control of a flash device
// Assumes: cycle decode upstream; cmd is a one-cycle pulse
// Notes:   array itself lives outside; opStart/abort drive it
`timescale 1ns/1ps
module fmrc_mode_reset_ctrl
    import fmrc_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rstn,
    input  wire logic            devResetPin_n,
    input  wire logic            initPin_n,
    input  wire logic            muxModeSel,
    input  wire logic            progSupplyLockout,
    input  wire logic            coreSupplyLockout,
    input  wire fmrc_cmd_t       cmd,
    input  wire logic            cycleSelect,
    input  wire logic [3:0]      hubDataOut,
    input  wire fmrc_read_mode_t readModeReq,
    input  wire logic            readModeReqValid,
    input  wire fmrc_unlock_t    unlockReq,
    output logic                 readyBusyOut,
    output logic [3:0]           hubBusLinesOut,
    output logic [3:0]           hubBusLinesOe,
    output logic [2:0]           readMode,
    output logic [7:0]           statusOut,
    output logic [BLOCK_COUNT-1:0] blockLocked,
    output logic                 opStart,
    output logic                 opErase,
    output logic [BLOCK_IDX_W-1:0] opBlock,
    output logic                 opAbort,
    output logic                 dataInvalid
);
    logic [1:0] pinsSync;
    logic [1:0] lockSync;
    logic       devRst;
    logic       lockProg;
    logic       lockCore;

    fmrc_pin_sync #(.WIDTH(2), .INIT(2'b11)) u_rst_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pinIn    ({devResetPin_n, initPin_n}),
        .pinOut   (pinsSync)
    );
    fmrc_pin_sync #(.WIDTH(2), .INIT(2'b11)) u_lock_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pinIn    ({progSupplyLockout, coreSupplyLockout}),
        .pinOut   (lockSync)
    );
    assign devRst   = !(pinsSync[1] && pinsSync[0]);
    assign lockProg = lockSync[1];
    assign lockCore = lockSync[0];

    fmrc_wsm_t           wsm_ff;
    fmrc_read_mode_t     mode_ff;
    logic [15:0]         busyCnt_ff;
    logic [15:0]         rstLat_ff;
    logic                wasBusy_ff;
    logic [BLOCK_IDX_W-1:0] cmdBlock;
    logic                cmdTake;
    logic                goErase;
    logic                goProg;
    logic                ready;

    // any address decodes as a command write; only block index is used
    assign cmdBlock = cmd.addr[BLOCK_SHIFT+BLOCK_IDX_W-1:BLOCK_SHIFT];
    assign cmdTake  = cmd.valid && !devRst && !lockCore
                      && rstLat_ff == 16'h0000;
    assign goErase  = cmdTake && wsm_ff == FMRC_SETUP_ER
                      && cmd.data == CMD_ERASE_GO && !lockProg
                      && !blockLocked[cmdBlock];
    assign goProg   = cmdTake && wsm_ff == FMRC_SETUP_PR && !lockProg
                      && !blockLocked[cmdBlock];
    assign ready    = wsm_ff != FMRC_BUSY;

    always_ff @(posedge core_clk) begin
        if (!rstn || devRst) begin
            wsm_ff      <= FMRC_IDLE;
            busyCnt_ff  <= 16'h0000;
        end else begin
            unique case (wsm_ff)
                FMRC_IDLE: begin
                    if (cmdTake && cmd.data == CMD_ERASE_SETUP) begin
                        wsm_ff <= FMRC_SETUP_ER;
                    end else if (cmdTake && (cmd.data == CMD_PROG_SETUP
                                 || cmd.data == CMD_PROG_SETUP2)) begin
                        wsm_ff <= FMRC_SETUP_PR;
                    end
                end
                FMRC_SETUP_ER, FMRC_SETUP_PR: begin
                    if (goErase || goProg) begin
                        wsm_ff      <= FMRC_BUSY;
                        busyCnt_ff  <= OP_CYCLES;
                    end else if (cmdTake) begin
                        wsm_ff <= FMRC_IDLE;
                    end
                end
                FMRC_BUSY: begin
                    if (busyCnt_ff == 16'h0001) begin
                        wsm_ff <= FMRC_IDLE;
                    end
                    busyCnt_ff <= busyCnt_ff - 16'h0001;
                end
            endcase
        end
    end

    // reset latency and abort marking
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rstLat_ff   <= 16'h0000;
            wasBusy_ff  <= 1'b0;
            opAbort     <= 1'b0;
            dataInvalid <= 1'b0;
        end else begin
            opAbort <= devRst && wsm_ff == FMRC_BUSY;
            if (devRst) begin
                rstLat_ff  <= wasBusy_ff || wsm_ff == FMRC_BUSY
                              ? RESET_LAT_CYCLES : 16'h0000;
                wasBusy_ff <= wasBusy_ff || wsm_ff == FMRC_BUSY;
            end else begin
                wasBusy_ff <= 1'b0;
                if (rstLat_ff != 16'h0000) begin
                    rstLat_ff <= rstLat_ff - 16'h0001;
                end
            end
            if (devRst && wsm_ff == FMRC_BUSY) begin
                dataInvalid <= 1'b1;
            end else if (goErase || goProg) begin
                dataInvalid <= 1'b0;
            end
        end
    end

    // read mode: reset always returns to array reads
    always_ff @(posedge core_clk) begin
        if (!rstn || devRst) begin
            mode_ff <= FMRC_RD_ARRAY;
        end else if (cmdTake && cmd.data == CMD_READ_ARRAY) begin
            mode_ff <= FMRC_RD_ARRAY;
        end else if (cmdTake && cmd.data == CMD_READ_ID) begin
            mode_ff <= FMRC_RD_ID;
        end else if (cmdTake && (cmd.data == CMD_READ_STATUS
                     || wsm_ff != FMRC_BUSY && (goErase || goProg))) begin
            mode_ff <= FMRC_RD_STATUS;
        end else if (readModeReqValid && !devRst) begin
            mode_ff <= readModeReq;
        end
    end
    assign readMode = mode_ff;

    always_ff @(posedge core_clk) begin
        if (!rstn || devRst) begin
            blockLocked <= LOCK_RESET;
        end else if (unlockReq.valid) begin
            // lock bits are held here; only unlock requests clear them, reset sets them
            blockLocked[unlockReq.block] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            statusOut    <= STATUS_RESET;
            readyBusyOut <= 1'b1;
            opStart      <= 1'b0;
            opErase      <= 1'b0;
            opBlock      <= '0;
        end else begin
            statusOut[READY_BIT] <= ready;
            statusOut[6:0]       <= 7'h00;
            readyBusyOut <= muxModeSel ? ready : 1'b1;
            opStart      <= goErase || goProg;
            opErase      <= goErase;
            // held from the go write so the array side may latch late
            if (goErase || goProg) begin
                opBlock <= cmdBlock;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            hubBusLinesOut <= 4'h0;
            hubBusLinesOe  <= 4'h0;
        end else begin
            hubBusLinesOut <= hubDataOut;
            hubBusLinesOe  <= {4{cycleSelect && !devRst
                              && !muxModeSel}};
        end
    end

    property p_ready_bit;
        @(posedge core_clk) disable iff (!rstn)
        muxModeSel |=> readyBusyOut == statusOut[READY_BIT];
    endproperty
    a_ready_bit: assert property (p_ready_bit)
        else $error("ready output differs from status bit");

    property p_busy_after_start;
        @(posedge core_clk) disable iff (!rstn)
        (goErase || goProg) && !devRst |=> ##1 !statusOut[READY_BIT];
    endproperty
    a_busy_after_start: assert property (p_busy_after_start)
        else $error("status not busy after start");

    property p_reset_array;
        @(posedge core_clk) disable iff (!rstn)
        devRst |=> mode_ff == FMRC_RD_ARRAY;
    endproperty
    a_reset_array: assert property (p_reset_array)
        else $error("reset did not select array reads");

    property p_float;
        @(posedge core_clk) disable iff (!rstn)
        !cycleSelect |=> hubBusLinesOe == 4'h0;
    endproperty
    a_float: assert property (p_float)
        else $error("hub lines driven while deselected");

    property p_lock_reset;
        @(posedge core_clk) disable iff (!rstn)
        devRst |=> blockLocked == LOCK_RESET;
    endproperty
    a_lock_reset: assert property (p_lock_reset)
        else $error("blocks not locked after reset");

    property p_abort;
        @(posedge core_clk) disable iff (!rstn)
        devRst && wsm_ff == FMRC_BUSY |=> opAbort && dataInvalid;
    endproperty
    a_abort: assert property (p_abort)
        else $error("busy operation not aborted");

    property p_prog_lock;
        @(posedge core_clk) disable iff (!rstn)
        lockProg || lockCore |=> !opStart;
    endproperty
    a_prog_lock: assert property (p_prog_lock)
        else $error("operation started under lockout");

    property p_core_lock;
        @(posedge core_clk) disable iff (!rstn)
        lockCore && wsm_ff == FMRC_IDLE |=> wsm_ff == FMRC_IDLE;
    endproperty
    a_core_lock: assert property (p_core_lock)
        else $error("command taken under core lockout");

    c_start: cover property (@(posedge core_clk) opStart);
    c_abort: cover property (@(posedge core_clk) opAbort);
    c_status: cover property (@(posedge core_clk)
        mode_ff == FMRC_RD_STATUS);
endmodule // fmrc_mode_reset_ctrl

// ==== tb/fmrc_host_model.sv ====
// Purpose: host chipset model that issues command writes
// Assumes: one write per call, valid high for one cycle
// Notes:   released fields carry inverted values, never the last ones
`timescale 1ns/1ps
module fmrc_host_model
    import fmrc_pkg::*;
(
    input  wire logic core_clk,
    output fmrc_cmd_t cmd
);
    initial begin
        cmd = '0;
    end

    // block commands carry an address inside the target block
    task automatic sendCmd(input logic [ADDR_W-1:0] addr,
                           input logic [7:0]        data);
        @(posedge core_clk);
        cmd <= '{valid: 1'b1, addr: addr, data: data};
        @(posedge core_clk);
        cmd <= '{valid: 1'b0, addr: ~addr, data: ~data};
    endtask
endmodule // fmrc_host_model

// ==== tb/flash_mode_reset_control_tb.sv ====
// Purpose: self-checking bench for the mode/reset control
// Assumes: 250 MHz clock, block 3 unlocked only by the unlock request
// Notes: reset values first, then table rows, lockout and pin-reset cases
`timescale 1ns/1ps
module flash_mode_reset_control_tb
    import fmrc_pkg::*;
;
    typedef struct packed {
        logic sel; logic mux; logic [3:0] hub; logic isReq;
        logic [7:0] val; logic [3:0] expOe; logic [2:0] expMode;
    } fmrc_row_t;

    logic core_clk, rstn, devResetPin_n, initPin_n, muxModeSel;
    logic progSupplyLockout, coreSupplyLockout, cycleSelect;
    logic readModeReqValid, readyBusyOut, opStart, opErase, opAbort;
    logic dataInvalid, sawStart, sawErase, sawAbort;
    logic [3:0] hubDataOut, hubBusLinesOut, hubBusLinesOe, opBlock;
    logic [2:0] readMode;
    logic [7:0] statusOut;
    logic [BLOCK_COUNT-1:0] blockLocked;
    fmrc_read_mode_t readModeReq;
    fmrc_cmd_t cmd;
    fmrc_unlock_t unlockReq;
    int fails, check_count, cycles;
    fmrc_row_t rows [8] = '{
        '{1'b1, 1'b0, 4'ha, 1'b0, 8'hff, 4'hf, 3'h0},
        '{1'b0, 1'b0, 4'h5, 1'b0, 8'h90, 4'h0, 3'h1},
        '{1'b1, 1'b1, 4'h3, 1'b0, 8'h70, 4'h0, 3'h2},
        '{1'b1, 1'b0, 4'hc, 1'b1, 8'h03, 4'hf, 3'h3},
        '{1'b0, 1'b1, 4'h0, 1'b1, 8'h04, 4'h0, 3'h4},
        '{1'b1, 1'b0, 4'h6, 1'b1, 8'h05, 4'hf, 3'h5},
        '{1'b0, 1'b0, 4'h9, 1'b1, 8'h06, 4'h0, 3'h6},
        '{1'b1, 1'b0, 4'h1, 1'b0, 8'hff, 4'hf, 3'h0}};
    logic [7:0] progSeq [6] = '{8'h20, 8'hd0, 8'h40, 8'h55, 8'h10, 8'haa};

    fmrc_host_model host (.core_clk(core_clk), .cmd(cmd));

    fmrc_mode_reset_ctrl dut (
        .core_clk(core_clk), .rstn(rstn), .devResetPin_n(devResetPin_n),
        .initPin_n(initPin_n), .muxModeSel(muxModeSel),
        .progSupplyLockout(progSupplyLockout),
        .coreSupplyLockout(coreSupplyLockout), .cmd(cmd),
        .cycleSelect(cycleSelect), .hubDataOut(hubDataOut),
        .readModeReq(readModeReq), .readModeReqValid(readModeReqValid),
        .unlockReq(unlockReq),
        .readyBusyOut(readyBusyOut), .hubBusLinesOut(hubBusLinesOut),
        .hubBusLinesOe(hubBusLinesOe), .readMode(readMode),
        .statusOut(statusOut), .blockLocked(blockLocked),
        .opStart(opStart), .opErase(opErase), .opBlock(opBlock),
        .opAbort(opAbort), .dataInvalid(dataInvalid));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [15:0] exp, input logic [15:0] act);
        check_count++;
        if (act !== exp) begin
            fails++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, act);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic waitN(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // sticky so a one-cycle start pulse cannot slip between checks
    always @(posedge core_clk) begin
        cycles++;
        if (opStart === 1'b1) begin
            sawStart <= 1'b1;
        end
        if (opStart === 1'b1 && opErase === 1'b1) begin
            sawErase <= 1'b1;
        end
        if (opAbort === 1'b1) begin
            sawAbort <= 1'b1;
        end
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        rstn = 1'b0; devResetPin_n = 1'b1; initPin_n = 1'b1;
        muxModeSel = 1'b0; progSupplyLockout = 1'b0; sawStart = 1'b0;
        sawErase = 1'b0;
        sawAbort = 1'b0;
        unlockReq = '0;
        coreSupplyLockout = 1'b0; cycleSelect = 1'b0; hubDataOut = 4'h0;
        readModeReq = FMRC_RD_ARRAY; readModeReqValid = 1'b0;
        waitN(16);
        rstn <= 1'b1;
        waitN(8);
        chk(16'h1, readyBusyOut);
        chk(16'h0, hubBusLinesOe);
        chk(16'h80, statusOut);
        chk(16'hffff, blockLocked);
        chk(16'h0, readMode);
        foreach (rows[i]) begin
            cycleSelect <= rows[i].sel;
            muxModeSel <= rows[i].mux;
            hubDataOut <= rows[i].hub;
            progSupplyLockout <= i[0];
            if (rows[i].isReq) begin
                @(posedge core_clk);
                readModeReq <= fmrc_read_mode_t'(rows[i].val[2:0]);
                readModeReqValid <= 1'b1;
                @(posedge core_clk);
                readModeReqValid <= 1'b0;
            end else begin
                host.sendCmd({i[3:0], 16'h1234}, rows[i].val);
            end
            waitN(8);
            chk(rows[i].expMode, readMode);
            chk(rows[i].expOe, hubBusLinesOe);
            if (rows[i].expOe != 4'h0) begin
                chk(rows[i].hub, hubBusLinesOut);
            end
        end
        // erase and both program setups aimed at block 3, locked for the first two
        muxModeSel <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            progSupplyLockout <= (k == 2);
            // last pass: block unlocked, so only the lockout refuses
            unlockReq <= '{valid: (k == 2), block: 4'h3};
            waitN(6);
            unlockReq.valid <= 1'b0;
            host.sendCmd(20'h30100, progSeq[2*k]);
            host.sendCmd(20'h30100, progSeq[2*k+1]);
            waitN(6);
            chk(16'h0, sawStart);
            chk(16'h80, statusOut);
            chk(16'h1, readyBusyOut);
        end
        // block 3 unlocked: a full erase, then one cut by a pin reset
        progSupplyLockout <= 1'b0;
        waitN(6);
        host.sendCmd(20'h3abcd, CMD_ERASE_SETUP);
        host.sendCmd(20'h3abcd, CMD_ERASE_GO);
        waitN(2);
        chk(16'h1, sawErase);
        chk(16'h3, opBlock);
        chk(16'h0, statusOut);
        chk(16'h0, readyBusyOut);
        waitN(OP_CYCLES - 1);
        chk(16'h0, readyBusyOut);
        waitN(1);
        chk(16'h80, statusOut);
        chk(16'h1, readyBusyOut);
        host.sendCmd(20'h3abcd, CMD_ERASE_SETUP);
        host.sendCmd(20'h3abcd, CMD_ERASE_GO);
        devResetPin_n <= 1'b0;
        waitN(10);
        chk(16'h1, sawAbort);
        chk(16'h1, dataInvalid);
        chk(16'hffff, blockLocked);
        devResetPin_n <= 1'b1;
        // lands inside the reset latency, so it must be dropped
        waitN(6);
        host.sendCmd(20'h00000, CMD_READ_STATUS);
        waitN(4);
        chk(16'h0, readMode);
        // core lockout: command must be dropped
        progSupplyLockout <= 1'b0;
        coreSupplyLockout <= 1'b1;
        waitN(6);
        host.sendCmd(20'h00000, CMD_READ_STATUS);
        waitN(6);
        chk(16'h0, readMode);
        coreSupplyLockout <= 1'b0;
        muxModeSel <= 1'b0;
        cycleSelect <= 1'b1;
        waitN(6);
        for (int p = 0; p < 2; p++) begin
            host.sendCmd(20'hfffff, CMD_READ_STATUS);
            waitN(4);
            chk(16'h2, readMode);
            if (p == 0) devResetPin_n <= 1'b0;
            else initPin_n <= 1'b0;
            waitN(10);
            chk(16'h0, hubBusLinesOe);
            devResetPin_n <= 1'b1;
            initPin_n <= 1'b1;
            waitN(20);
            chk(16'h0, readMode);
            chk(16'hffff, blockLocked);
            chk(16'h0, opAbort);
        end
        tally_and_finish();
    end
endmodule // flash_mode_reset_control_tb
